// *** design/lsi_pkg.sv ***
// Shared constants for the LED status indicator block
package lsi_pkg;

  // Register byte addresses on APB
  localparam logic [11:0] ADDR_LED_STATUS = 12'h000;
  localparam logic [11:0] ADDR_MISC_CFG   = 12'h004;
  localparam int          ADDR_W          = 12;

  // Field positions of led_pin_b_status
  localparam int BIT_COLLISION  = 0;
  localparam int BIT_RX_DELIM   = 1;
  localparam int BIT_RX         = 2;
  localparam int BIT_RSVD3      = 3;
  localparam int BIT_TX         = 4;
  localparam int BIT_RX_MATCH   = 5;
  localparam int BIT_LINK       = 6;
  localparam int BIT_STRETCH    = 7;
  localparam int BIT_FDX_LINK   = 8;
  localparam int BIT_FAST_SPEED = 12;
  localparam int BIT_LED_OFF    = 13;
  localparam int BIT_POLARITY   = 14;
  localparam int BIT_STATE      = 15;

  // Field position of misc_config_reg
  localparam int BIT_PROG_EN = 12;

  // Bits that software or the EEPROM may store
  localparam logic [15:0] CFG_WR_MASK = 16'h71f7;

  // Hard reset values, first and second LED instance
  localparam logic [15:0] RST_CFG_FIRST  = 16'h00c0;
  localparam logic [15:0] RST_CFG_SECOND = 16'h0094;
  localparam logic        RST_PROG_EN    = 1'b0;

  // MII nibble values around the start of frame
  localparam logic [3:0] NIB_PREAMBLE = 4'h5;
  localparam logic [3:0] NIB_SFD      = 4'hd;

  // Pulse stretch time
  localparam int CLK_MHZ         = 100;
  localparam int STRETCH_TIME_US = 20000;
  localparam int STRETCH_CYCLES  = STRETCH_TIME_US * CLK_MHZ;

  typedef enum logic [1:0] {
    LSI_RX_IDLE,
    LSI_RX_PREAMBLE,
    LSI_RX_DATA
  } lsi_rx_state_e;

endpackage

// *** design/lsi_led_status.sv ***
// LED status indicator: event selection, stretcher, pin drive and APB registers
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - Stretch enable extends on-time, else pin follows
// - First instance resets stretch enable to one
// - Link enable passes link pass state
// - First instance resets link enable to one
// - Match enable passes address-matched receive activity
// - Transmit enable passes transmit activity
// - Receive enable passes any receive activity
// - Delimiter enable passes low nibble of data
// - Collision enable passes collision activity
// - State bit reads unstretched OR of events
// - OR built from per-bit gated event sources
// - State bit read-only, untouched by resets
// - Second instance resets transmit, receive, stretch
// - Programming enable gates APB writes to led_pin_b_status only
// - EEPROM loads the lower sixteen bits
// - Upper sixteen bits written as zero
// - Bit three reserved, reads zero
// - Other enables cleared by hard reset only
// - Polarity selects open drain or totem pole
// - Disable bit forces pin inactive
// - Full-duplex link enable passes link plus duplex
// - Speed enable passes 100 Mbps operation
module lsi_led_status #(
  parameter int SECOND_INSTANCE = 1,
  parameter int STRETCH_CYCLES  = lsi_pkg::STRETCH_CYCLES
) (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       srst,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [lsi_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // EEPROM configuration load
  input  wire logic                       eeprom_load,
  input  wire logic [15:0]                eeprom_data,
  // Network events from the MAC and address filter
  input  wire logic                       link_pass,
  input  wire logic                       fdx_mode,
  input  wire logic                       speed_100,
  input  wire logic                       rx_match_act,
  input  wire logic                       tx_act,
  input  wire logic                       rx_act,
  input  wire logic                       collision_act,
  // MII receive pins
  input  wire logic                       mii_rx_clk,
  input  wire logic                       mii_rx_dv,
  input  wire logic [3:0]                 mii_rxd,
  // LED pin
  output logic                            led_pin_b_o,
  output logic                            led_pin_b_oe
);

  localparam int CNT_W = $clog2(STRETCH_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(STRETCH_CYCLES);

  // Configuration state
  logic [15:0] led_cfg;
  logic [15:0] next_led_cfg;
  logic        led_prog_en;
  logic        next_led_prog_en;

  // APB read path state
  logic [31:0] next_prdata;
  logic        next_pslverr;

  // MII synchronisers
  logic [1:0]  rx_clk_sync;
  logic [1:0]  rx_dv_sync;
  logic [3:0]  rxd_meta;
  logic [3:0]  rxd_sync;
  logic        rx_clk_prev;
  logic        next_rx_clk_prev;

  // Delimiter tracker
  lsi_pkg::lsi_rx_state_e rx_state;
  lsi_pkg::lsi_rx_state_e next_rx_state;
  logic        low_nibble;
  logic        next_low_nibble;
  logic        delim_act;
  logic        next_delim_act;

  // Status and stretcher
  logic        led_state_bit;
  logic        state_prev;
  logic        next_state_prev;
  logic [CNT_W-1:0] stretch_cnt;
  logic [CNT_W-1:0] next_stretch_cnt;
  logic        led_active;
  logic        next_led_o;
  logic        next_led_oe;

  // Write decode shared by both registers
  function automatic logic wr_hit(input logic [lsi_pkg::ADDR_W-1:0] addr,
                                  input logic [lsi_pkg::ADDR_W-1:0] target);
    wr_hit = psel && penable && pwrite && (addr == target);
  endfunction

  assign pready = 1'b1;

  // Configuration registers
  always_comb begin
    next_led_cfg     = led_cfg;
    next_led_prog_en = led_prog_en;
    if (wr_hit(paddr, lsi_pkg::ADDR_MISC_CFG)) begin
      next_led_prog_en = pwdata[lsi_pkg::BIT_PROG_EN];
    end
    if (wr_hit(paddr, lsi_pkg::ADDR_LED_STATUS) && led_prog_en) begin
      next_led_cfg = pwdata[15:0] & lsi_pkg::CFG_WR_MASK;
    end
    if (eeprom_load) begin
      next_led_cfg = eeprom_data & lsi_pkg::CFG_WR_MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      // Only hard reset touches the enables
      if (SECOND_INSTANCE != 0) begin
        led_cfg <= lsi_pkg::RST_CFG_SECOND;
      end else begin
        led_cfg <= lsi_pkg::RST_CFG_FIRST;
      end
      led_prog_en <= lsi_pkg::RST_PROG_EN;
    end else begin
      led_cfg     <= next_led_cfg;
      led_prog_en <= next_led_prog_en;
    end
  end

  // APB read data, captured in the setup phase
  always_comb begin
    next_prdata  = prdata;
    next_pslverr = pslverr;
    if (psel && !penable) begin
      next_prdata  = 32'h0000_0000;
      next_pslverr = 1'b0;
      case (paddr)
        lsi_pkg::ADDR_LED_STATUS: begin
          next_prdata[15:0] = led_cfg;
          next_prdata[lsi_pkg::BIT_STATE] = led_state_bit;
        end
        lsi_pkg::ADDR_MISC_CFG: begin
          next_prdata[lsi_pkg::BIT_PROG_EN] = led_prog_en;
        end
        default: begin
          next_pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Two-stage synchronisers on the MII pins
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rx_clk_sync <= 2'h0;
      rx_dv_sync  <= 2'h0;
      rxd_meta    <= 4'h0;
      rxd_sync    <= 4'h0;
    end else begin
      rx_clk_sync <= {rx_clk_sync[0], mii_rx_clk};
      rx_dv_sync  <= {rx_dv_sync[0], mii_rx_dv};
      rxd_meta    <= mii_rxd;
      rxd_sync    <= rxd_meta;
    end
  end

  // Nibble tracker: finds the delimiter, then marks every low data nibble
  always_comb begin
    next_rx_clk_prev = rx_clk_sync[1];
    next_rx_state    = rx_state;
    next_low_nibble  = low_nibble;
    next_delim_act   = delim_act;
    if (rx_clk_sync[1] && !rx_clk_prev) begin
      case (rx_state)
        lsi_pkg::LSI_RX_IDLE: begin
          next_low_nibble = 1'b0;
          if (rx_dv_sync[1] && rxd_sync == lsi_pkg::NIB_PREAMBLE) begin
            next_rx_state = lsi_pkg::LSI_RX_PREAMBLE;
          end
        end
        lsi_pkg::LSI_RX_PREAMBLE: begin
          if (!rx_dv_sync[1]) begin
            next_rx_state = lsi_pkg::LSI_RX_IDLE;
          end else if (rxd_sync == lsi_pkg::NIB_SFD) begin
            next_rx_state   = lsi_pkg::LSI_RX_DATA;
            next_low_nibble = 1'b1;
          end else if (rxd_sync != lsi_pkg::NIB_PREAMBLE) begin
            next_rx_state = lsi_pkg::LSI_RX_IDLE;
          end
        end
        lsi_pkg::LSI_RX_DATA: begin
          if (!rx_dv_sync[1]) begin
            next_rx_state   = lsi_pkg::LSI_RX_IDLE;
            next_low_nibble = 1'b0;
          end else begin
            next_low_nibble = !low_nibble;
          end
        end
        default: begin
          next_rx_state   = lsi_pkg::LSI_RX_IDLE;
          next_low_nibble = 1'b0;
        end
      endcase
      // Nibble now on the pins is the low half of a data byte
      next_delim_act = rx_dv_sync[1] && (rx_state == lsi_pkg::LSI_RX_DATA) && low_nibble;
    end
    if (!rx_dv_sync[1]) begin
      next_delim_act = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rx_clk_prev <= 1'b0;
      rx_state    <= lsi_pkg::LSI_RX_IDLE;
      low_nibble  <= 1'b0;
      delim_act   <= 1'b0;
    end else begin
      rx_clk_prev <= next_rx_clk_prev;
      rx_state    <= next_rx_state;
      low_nibble  <= next_low_nibble;
      delim_act   <= next_delim_act;
    end
  end

  // Unstretched status: OR of gated events, no storage of its own
  always_comb begin
    led_state_bit =
      (led_cfg[lsi_pkg::BIT_COLLISION]  && collision_act)        ||
      (led_cfg[lsi_pkg::BIT_RX_DELIM]   && delim_act)            ||
      (led_cfg[lsi_pkg::BIT_RX]         && rx_act)               ||
      (led_cfg[lsi_pkg::BIT_TX]         && tx_act)               ||
      (led_cfg[lsi_pkg::BIT_RX_MATCH]   && rx_match_act)         ||
      (led_cfg[lsi_pkg::BIT_LINK]       && link_pass)            ||
      (led_cfg[lsi_pkg::BIT_FDX_LINK]   && link_pass && fdx_mode) ||
      (led_cfg[lsi_pkg::BIT_FAST_SPEED] && speed_100);
  end

  // Stretcher: reloads in every cycle that the status is high
  always_comb begin
    next_state_prev  = led_state_bit;
    next_stretch_cnt = stretch_cnt;
    if (led_state_bit && !state_prev) begin
      next_stretch_cnt = CNT_LOAD;
    end else if (led_state_bit) begin
      next_stretch_cnt = CNT_LOAD;
    end else if (stretch_cnt != '0) begin
      next_stretch_cnt = stretch_cnt - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_prev  <= 1'b0;
      stretch_cnt <= '0;
    end else begin
      state_prev  <= next_state_prev;
      stretch_cnt <= next_stretch_cnt;
    end
  end

  // Pin drive
  always_comb begin
    if (led_cfg[lsi_pkg::BIT_STRETCH]) begin
      led_active = led_state_bit || (stretch_cnt != '0);
    end else begin
      led_active = led_state_bit;
    end
    if (led_cfg[lsi_pkg::BIT_LED_OFF]) begin
      next_led_o  = 1'b0;
      next_led_oe = 1'b0;
    end else if (led_cfg[lsi_pkg::BIT_POLARITY]) begin
      next_led_o  = led_active;
      next_led_oe = 1'b1;
    end else begin
      next_led_o  = 1'b0;
      next_led_oe = led_active;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      led_pin_b_o  <= 1'b0;
      led_pin_b_oe <= 1'b0;
    end else begin
      led_pin_b_o  <= next_led_o;
      led_pin_b_oe <= next_led_oe;
    end
  end

endmodule

`default_nettype wire

// *** sim/lsi_led_status_properties.sv ***
// Concurrent checks on the LED status indicator ports
`timescale 1ns/1ns
`default_nettype none
module lsi_led_status_properties #(
  parameter int SECOND_INSTANCE = 1,
  parameter int STRETCH_CYCLES  = 8
) (
  // Clock and reset
  input wire logic                       sys_clk,
  input wire logic                       srst,
  // APB
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [lsi_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                pwdata,
  input wire logic [31:0]                prdata,
  input wire logic                       pslverr,
  // Configuration and events
  input wire logic                       eeprom_load,
  input wire logic [15:0]                eeprom_data,
  input wire logic                       link_pass,
  input wire logic                       fdx_mode,
  input wire logic                       speed_100,
  input wire logic                       rx_match_act,
  input wire logic                       tx_act,
  input wire logic                       rx_act,
  input wire logic                       collision_act,
  // LED pin
  input wire logic                       led_pin_b_o,
  input wire logic                       led_pin_b_oe
);
  logic [15:0] sh, next_sh;
  logic        pe, next_pe, st, acc, rd_led, act0, act1;
  int          cnt, next_cnt;
  assign acc = psel && penable && pwrite;
  assign rd_led = psel && penable && !pwrite && paddr == lsi_pkg::ADDR_LED_STATUS;
  assign act0 = led_pin_b_oe && !led_pin_b_o;
  assign act1 = led_pin_b_oe && led_pin_b_o;
  assign st = (sh[0] && collision_act) || (sh[2] && rx_act) || (sh[4] && tx_act)
    || (sh[5] && rx_match_act) || (sh[6] && link_pass) || (sh[12] && speed_100)
    || (sh[8] && link_pass && fdx_mode);
  // Shadow of the stored fields and of the stretch counter
  always_comb begin
    next_sh = sh;
    next_pe = pe;
    next_cnt = st ? STRETCH_CYCLES : ((cnt > 0) ? cnt - 1 : 0);
    if (acc && paddr == lsi_pkg::ADDR_MISC_CFG) next_pe = pwdata[lsi_pkg::BIT_PROG_EN];
    if (acc && paddr == lsi_pkg::ADDR_LED_STATUS && pe) next_sh = pwdata[15:0] & lsi_pkg::CFG_WR_MASK;
    if (eeprom_load) next_sh = eeprom_data & lsi_pkg::CFG_WR_MASK;
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sh  <= (SECOND_INSTANCE != 0) ? lsi_pkg::RST_CFG_SECOND : lsi_pkg::RST_CFG_FIRST;
      pe  <= lsi_pkg::RST_PROG_EN;
      cnt <= 0;
    end else begin
      sh  <= next_sh;
      pe  <= next_pe;
      cnt <= next_cnt;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  AST_STATE_READ: assert property (rd_led && !$past(sh[1]) |-> prdata[15] == $past(st))
    else $error("state bit differs from enabled OR");
  AST_CFG_READ: assert property (rd_led |-> prdata[14:0] == $past(sh[14:0]))
    else $error("stored fields differ from expected");
  AST_UPPER_ZERO: assert property (rd_led |-> prdata[31:16] == 16'h0000)
    else $error("upper half not zero");
  AST_RSVD3: assert property (rd_led |-> !prdata[3] && !$past(prdata[3]))
    else $error("reserved bit three set");
  AST_OFF: assert property ($past(sh[13]) |-> !led_pin_b_oe)
    else $error("pin driven while disabled");
  AST_POL0_NO_HIGH: assert property (!$past(sh[14]) |-> !act1)
    else $error("open drain pin driven high");
  AST_DIRECT: assert property (!$past(sh[7]) && !$past(sh[13]) && !$past(sh[1])
    |-> ($past(sh[14]) ? act1 : act0) == $past(st))
    else $error("unstretched pin does not follow state");
  AST_STRETCH: assert property ($past(sh[7]) && !$past(sh[13]) && !$past(sh[1])
    |-> ($past(sh[14]) ? act1 : act0) == $past(st || cnt != 0))
    else $error("stretched pin timing wrong");
endmodule
bind lsi_led_status lsi_led_status_properties #(
  .SECOND_INSTANCE(SECOND_INSTANCE), .STRETCH_CYCLES(STRETCH_CYCLES)
) u_props (
  .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .eeprom_load(eeprom_load), .eeprom_data(eeprom_data), .link_pass(link_pass),
  .fdx_mode(fdx_mode), .speed_100(speed_100), .rx_match_act(rx_match_act),
  .tx_act(tx_act), .rx_act(rx_act), .collision_act(collision_act),
  .led_pin_b_o(led_pin_b_o), .led_pin_b_oe(led_pin_b_oe)
);
`default_nettype wire

// *** sim/lsi_led_model.sv ***
// External LED on the status pin, with the board pull-up
`timescale 1ns/1ns
`default_nettype none
module lsi_led_model (
  // Pin from the block
  input  wire logic pin_o,
  input  wire logic pin_oe,
  // Resolved pin level
  output logic      pin_level
);
  // A released pin floats up to the pull-up level
  assign pin_level = pin_oe ? pin_o : 1'b1;
endmodule
`default_nettype wire

// *** sim/test_lsi_led_status.sv ***
// Self-checking bench for the LED status indicator
`timescale 1ns/1ns
`default_nettype none
module test_lsi_led_status;
  localparam int          S    = 8;
  localparam logic [11:0] LED  = lsi_pkg::ADDR_LED_STATUS;
  localparam logic [11:0] MISC = lsi_pkg::ADDR_MISC_CFG;
  logic        sys_clk, srst, psel, penable, pwrite, eeprom_load, pready, pslverr, rerr;
  logic        mii_rx_clk, mii_rx_dv, pin_o, pin_oe, pin_level;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] eeprom_data;
  logic [3:0]  mii_rxd;
  logic [6:0]  ev;
  int          err_total, checks_done, hi_base;
  int          cyc    = 0;
  int          hi_cnt = 0;
  logic [15:0] en_t [8] = '{16'h0001, 16'h0004, 16'h0010, 16'h0020, 16'h0040, 16'h0100,
                            16'h0100, 16'h1000};
  logic [6:0]  ev_t [8] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h30, 7'h10, 7'h40};
  lsi_led_status #(.SECOND_INSTANCE(1), .STRETCH_CYCLES(S)) dut (
    .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .eeprom_load(eeprom_load), .eeprom_data(eeprom_data), .link_pass(ev[4]),
    .fdx_mode(ev[5]), .speed_100(ev[6]), .rx_match_act(ev[3]), .tx_act(ev[2]),
    .rx_act(ev[1]), .collision_act(ev[0]), .mii_rx_clk(mii_rx_clk), .mii_rx_dv(mii_rx_dv),
    .mii_rxd(mii_rxd), .led_pin_b_o(pin_o), .led_pin_b_oe(pin_oe));
  lsi_led_model u_led (.pin_o(pin_o), .pin_oe(pin_oe), .pin_level(pin_level));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (pin_level === 1'b1) hi_cnt <= hi_cnt + 1;
    if (cyc == 6000) begin
      err_total = err_total + 1;
      end_sim;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic nib(input logic [3:0] n);
    mii_rxd <= n;
    tick(2);
    mii_rx_clk <= 1'b1;
    tick(2);
    mii_rx_clk <= 1'b0;
  endtask
  initial begin
    {srst, psel, penable, pwrite, eeprom_load, mii_rx_clk, mii_rx_dv} = 7'h40;
    {paddr, pwdata, eeprom_data, mii_rxd, ev} = '0;
    {err_total, checks_done, hi_base} = '0;
    tick(6);
    srst <= 1'b0;
    rdchk(LED, 32'h0000_0094);
    rdchk(MISC, 32'h0);
    apb(1'b1, LED, 32'h0000_ffff);
    rdchk(LED, 32'h0000_0094);
    apb(1'b1, MISC, 32'h0000_1000);
    apb(1'b1, LED, 32'hffff_ffff);
    rdchk(LED, 32'h0000_71f7);
    apb(1'b0, 12'h008, 32'h0);
    chk(rerr, 1);
    $display("register test done");
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, LED, {16'h0, en_t[i] | 16'h4000});
      ev <= ev_t[i];
      rdchk(LED, {16'h0, i != 6, en_t[i][14:0] | 15'h4000});
      chk(pin_level, i != 6);
      ev <= 7'h00;
      rdchk(LED, {16'h0, en_t[i] | 16'h4000});
      chk(pin_level, 0);
    end
    $display("event test done");
    apb(1'b1, LED, 32'h0000_4002);
    mii_rx_dv <= 1'b1;
    hi_base = hi_cnt;
    for (int i = 0; i < 4; i++) nib(lsi_pkg::NIB_PREAMBLE);
    tick(4);
    chk(hi_cnt - hi_base, 0);
    nib(lsi_pkg::NIB_SFD);
    for (int i = 0; i < 4; i++) nib(4'h3);
    tick(4);
    chk(hi_cnt != hi_base, 1);
    mii_rx_dv <= 1'b0;
    tick(S + 4);
    $display("delimiter test done");
    apb(1'b1, LED, 32'h0000_0010);
    ev <= 7'h04;
    tick(3);
    chk(pin_level, 0);
    ev <= 7'h00;
    tick(3);
    chk({pin_level, pin_oe}, 2'b10);
    apb(1'b1, LED, 32'h0000_2010);
    ev <= 7'h04;
    tick(3);
    chk(pin_oe, 0);
    ev <= 7'h00;
    apb(1'b1, LED, 32'h0000_4090);
    ev <= 7'h04;
    tick(1);
    ev <= 7'h00;
    tick(S - 1);
    chk(pin_level, 1);
    tick(5);
    chk(pin_level, 0);
    $display("pin test done");
    apb(1'b1, MISC, 32'h0);
    eeprom_data <= 16'hffff;
    eeprom_load <= 1'b1;
    tick(1);
    eeprom_load <= 1'b0;
    rdchk(LED, 32'h0000_71f7);
    apb(1'b1, LED, 32'h0);
    rdchk(LED, 32'h0000_71f7);
    $display("load test done");
    end_sim;
  end
endmodule
`default_nettype wire
